// >>> shared/amgc_defines.svh
// register offsets, field positions, reset values and masks of the audio mode and gain bank
`ifndef AMGC_DEFINES_SVH
`define AMGC_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define AMGC_ADDR_PLAYBACK_CFG 8'h16
`define AMGC_ADDR_POWER_SAVE 8'h17
`define AMGC_ADDR_RIGHT_MIC_GAIN 8'h30
`define AMGC_ADDR_LEFT_MIC_GAIN 8'h31
`define AMGC_ADDR_RIGHT_MON_GAIN 8'h32
`define AMGC_ADDR_LEFT_MON_GAIN 8'h33
`define AMGC_ADDR_ALT_GAIN_CFG 8'h40
`define AMGC_ADDR_ALT_RIGHT_GAIN 8'h41
`define AMGC_ADDR_ALT_LEFT_GAIN 8'h42
`define AMGC_NUM_REGS 9

// ****************************************
// field positions
// ****************************************
`define AMGC_BIT_TEST 7
`define AMGC_BIT_PLAYBACK_DISABLE 6
`define AMGC_BIT_PREAMP_POWER_SAVE 4
`define AMGC_BIT_FILTER_RIGHT_EN 1
`define AMGC_BIT_FILTER_LEFT_EN 0
`define AMGC_BIT_SLIDE_SWITCH 7
`define AMGC_BIT_HEADPHONE_SAVE 3
`define AMGC_BIT_MIC_AMP_SAVE 2
`define AMGC_BIT_FILTER_AMP_SAVE 0
`define AMGC_BIT_ALT_GAIN_SELECT 7
`define AMGC_GAIN_MSB 5

// ****************************************
// reset values and masks
// ****************************************
`define AMGC_RST_PLAYBACK_CFG 8'h00
`define AMGC_RST_POWER_SAVE 8'h00
`define AMGC_RST_MIC_GAIN 8'h80
`define AMGC_RST_MON_GAIN 8'h00
`define AMGC_RST_ALT_GAIN_CFG 8'h00
`define AMGC_RST_ALT_GAIN 8'h00
`define AMGC_WMASK_PLAYBACK_CFG 8'h53
`define AMGC_ROVAL_PLAYBACK_CFG 8'h80
`define AMGC_WMASK_POWER_SAVE 8'h8d
`define AMGC_WMASK_MIC_GAIN 8'hbf
`define AMGC_WMASK_GAIN_CODE 8'h3f
`define AMGC_WMASK_ALT_GAIN_CFG 8'h80
`define AMGC_GAIN_MON_KNEE 6'h3e

`endif

// >>> shared/amgc_pkg.sv
// types shared by the audio mode and gain bank
`default_nettype none
package amgc_pkg;

    // ****************************************
    // host port request
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } amgc_bus_req_t;

    // ****************************************
    // decoded gain: mute flag and gain in 0.5 dB units
    // ****************************************
    typedef struct packed {
        logic mute;
        logic [5:0] half_db;
    } amgc_gain_t;

    // ****************************************
    // control outputs toward the analog blocks
    // ****************************************
    typedef struct packed {
        logic playback_only_disable;
        logic playback_preamp_power_save;
        logic playback_filter_amp_right_en;
        logic playback_filter_amp_left_en;
        logic slide_switch_power_ctrl;
        logic headphone_power_save_en;
        logic mic_amp_power_save_en;
        logic filter_amp_power_save_en;
        logic alternative_gain_select;
        amgc_gain_t right_mic_gain;
        amgc_gain_t left_mic_gain;
        amgc_gain_t right_monitor_gain;
        amgc_gain_t left_monitor_gain;
    } amgc_ctrl_t;

endpackage
`default_nettype wire

// >>> design/amgc_field_reg.sv
// one 8-bit configuration register with writable mask and constant read-only bits
`default_nettype none
module amgc_field_reg
    import amgc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff,
    parameter logic [7:0] RO_VAL = 8'h00
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] value_out
);

    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // unlisted bits never store, so they read zero [R16]
    assign q_nxt = wdata_in & WR_MASK;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q_r <= RESET_VAL & WR_MASK; // [R16]
        end else if (wr_en_in) begin
            q_r <= q_nxt;
        end
    end

    // read-only bits are constants, a write cannot reach them [R1]
    assign value_out = q_r | RO_VAL;

endmodule
`default_nettype wire

// >>> design/amgc_gain_decode.sv
// decodes a 6-bit gain code into mute and 0.5 dB steps
`default_nettype none
`include "amgc_defines.svh"
module amgc_gain_decode
    import amgc_pkg::*;
#(
    parameter logic MONITOR = 1'b0
) (
    input wire logic [5:0] code_in,
    output amgc_gain_t gain_out
);

    logic is_mute;
    logic [5:0] mic_steps;
    logic [5:0] mon_steps;

    assign is_mute = (code_in == 6'h00);
    // code 1 is 0 dB, code 63 is 31 dB [R10] [R11]
    assign mic_steps = is_mute ? 6'h00 : (code_in - 6'h01);
    // code 1 is 0.5 dB; top two codes land on 30.5 and 31 dB [R12] [R13]
    assign mon_steps = (code_in >= `AMGC_GAIN_MON_KNEE) ? (code_in - 6'h01) : code_in;

    assign gain_out.mute = is_mute;
    assign gain_out.half_db = MONITOR ? mon_steps : mic_steps;

endmodule
`default_nettype wire

// >>> design/amgc_bank.sv
// configuration register bank for playback, power save and microphone gains
//
// Operation
// R1: playback test bit reads one, read-only
// R2: playback bit 6 disables playback-only mode
// R3: playback bit 4 enables preamp power save
// R4: playback bit 1 enables right filter amp
// R5: playback bit 0 enables left filter amp
// R6: power-save bit 7 enables slide-switch control
// R7: power-save bit 3 enables headphone power save
// R8: power-save bit 2 enables mic amp save
// R9: power-save bit 0 enables filter amp save
// R10: right mic code 0 mute, 1 0dB
// R11: left mic code 0 mute, 1 0dB
// R12: right monitor code 0 mute, 1 0.5dB
// R13: left monitor code 0 mute, 1 0.5dB
// R14: alternative select replaces mic gain registers
// R15: software sets slider only after slide-switch
// R16: unlisted bits read zero, defaults on reset
`default_nettype none
`include "amgc_defines.svh"
module amgc_bank
    import amgc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire amgc_bus_req_t bus_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output amgc_ctrl_t ctrl_out
);

    // ****************************************
    // register indices
    // ****************************************
    localparam int NREG = `AMGC_NUM_REGS;
    localparam int IDX_PLAYBACK = 0;
    localparam int IDX_POWER = 1;
    localparam int IDX_RMIC = 2;
    localparam int IDX_LMIC = 3;
    localparam int IDX_RMON = 4;
    localparam int IDX_LMON = 5;
    localparam int IDX_ALTCFG = 6;
    localparam int IDX_ALTR = 7;
    localparam int IDX_ALTL = 8;

    // ****************************************
    // per-register constants
    // ****************************************
    function automatic logic [7:0] reg_addr(input int idx);
        unique case (idx)
            IDX_PLAYBACK: reg_addr = `AMGC_ADDR_PLAYBACK_CFG;
            IDX_POWER: reg_addr = `AMGC_ADDR_POWER_SAVE;
            IDX_RMIC: reg_addr = `AMGC_ADDR_RIGHT_MIC_GAIN;
            IDX_LMIC: reg_addr = `AMGC_ADDR_LEFT_MIC_GAIN;
            IDX_RMON: reg_addr = `AMGC_ADDR_RIGHT_MON_GAIN;
            IDX_LMON: reg_addr = `AMGC_ADDR_LEFT_MON_GAIN;
            IDX_ALTCFG: reg_addr = `AMGC_ADDR_ALT_GAIN_CFG;
            IDX_ALTR: reg_addr = `AMGC_ADDR_ALT_RIGHT_GAIN;
            IDX_ALTL: reg_addr = `AMGC_ADDR_ALT_LEFT_GAIN;
            default: reg_addr = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_reset(input int idx);
        unique case (idx)
            IDX_PLAYBACK: reg_reset = `AMGC_RST_PLAYBACK_CFG;
            IDX_POWER: reg_reset = `AMGC_RST_POWER_SAVE;
            IDX_RMIC: reg_reset = `AMGC_RST_MIC_GAIN;
            IDX_LMIC: reg_reset = `AMGC_RST_MIC_GAIN;
            IDX_RMON: reg_reset = `AMGC_RST_MON_GAIN;
            IDX_LMON: reg_reset = `AMGC_RST_MON_GAIN;
            IDX_ALTCFG: reg_reset = `AMGC_RST_ALT_GAIN_CFG;
            IDX_ALTR: reg_reset = `AMGC_RST_ALT_GAIN;
            IDX_ALTL: reg_reset = `AMGC_RST_ALT_GAIN;
            default: reg_reset = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_wmask(input int idx);
        unique case (idx)
            IDX_PLAYBACK: reg_wmask = `AMGC_WMASK_PLAYBACK_CFG;
            IDX_POWER: reg_wmask = `AMGC_WMASK_POWER_SAVE;
            IDX_RMIC: reg_wmask = `AMGC_WMASK_MIC_GAIN;
            IDX_LMIC: reg_wmask = `AMGC_WMASK_MIC_GAIN;
            IDX_RMON: reg_wmask = `AMGC_WMASK_GAIN_CODE;
            IDX_LMON: reg_wmask = `AMGC_WMASK_GAIN_CODE;
            IDX_ALTCFG: reg_wmask = `AMGC_WMASK_ALT_GAIN_CFG;
            IDX_ALTR: reg_wmask = `AMGC_WMASK_GAIN_CODE;
            IDX_ALTL: reg_wmask = `AMGC_WMASK_GAIN_CODE;
            default: reg_wmask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_roval(input int idx);
        unique case (idx)
            IDX_PLAYBACK: reg_roval = `AMGC_ROVAL_PLAYBACK_CFG;
            default: reg_roval = 8'h00;
        endcase
    endfunction

    // address match, shared by the write and read paths
    function automatic logic addr_hit(input logic [7:0] addr, input int idx);
        addr_hit = (addr == reg_addr(idx));
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    logic [NREG-1:0] wr_sel;
    logic [NREG-1:0] rd_sel;
    logic [7:0] reg_value [NREG];
    logic [7:0] rd_chain [NREG+1];

    assign rd_chain[0] = 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            // unmapped addresses match nothing, so writes there vanish
            assign wr_sel[gi] = bus_in.wr & addr_hit(bus_in.addr, gi);
            assign rd_sel[gi] = bus_in.rd & addr_hit(bus_in.addr, gi);

            amgc_field_reg #(
                .RESET_VAL(reg_reset(gi)),
                .WR_MASK(reg_wmask(gi)),
                .RO_VAL(reg_roval(gi))
            ) u_reg (
                .mclk_in(mclk_in),
                .reset_n_in(reset_n_in),
                .wr_en_in(wr_sel[gi]),
                .wdata_in(bus_in.wdata),
                .value_out(reg_value[gi])
            ); // [R16]

            assign rd_chain[gi+1] = rd_chain[gi] | (rd_sel[gi] ? reg_value[gi] : 8'h00);
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;

    // unmapped reads answer zero; data stands one cycle only
    assign rdata_nxt = bus_in.rd ? rd_chain[NREG] : 8'h00;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt; // [R1] [R16]
            rvalid_r <= bus_in.rd;
        end
    end

    assign rdata_out = rdata_r;
    assign rvalid_out = rvalid_r;

    // ****************************************
    // field extraction
    // ****************************************
    logic [7:0] playback_word;
    logic [7:0] power_word;
    logic playback_only_disable;
    logic playback_preamp_power_save;
    logic playback_filter_amp_right_en;
    logic playback_filter_amp_left_en;
    logic slide_switch_power_ctrl;
    logic headphone_power_save_en;
    logic mic_amp_power_save_en;
    logic filter_amp_power_save_en;
    logic alternative_gain_select;

    assign playback_word = reg_value[IDX_PLAYBACK];
    assign power_word = reg_value[IDX_POWER];

    assign playback_only_disable = playback_word[`AMGC_BIT_PLAYBACK_DISABLE]; // [R2]
    assign playback_preamp_power_save = playback_word[`AMGC_BIT_PREAMP_POWER_SAVE]; // [R3]
    assign playback_filter_amp_right_en = playback_word[`AMGC_BIT_FILTER_RIGHT_EN]; // [R4]
    assign playback_filter_amp_left_en = playback_word[`AMGC_BIT_FILTER_LEFT_EN]; // [R5]

    // slider monitor setup elsewhere relies on this bit being set first [R15]
    assign slide_switch_power_ctrl = power_word[`AMGC_BIT_SLIDE_SWITCH]; // [R6]
    assign headphone_power_save_en = power_word[`AMGC_BIT_HEADPHONE_SAVE]; // [R7]
    assign mic_amp_power_save_en = power_word[`AMGC_BIT_MIC_AMP_SAVE]; // [R8]
    assign filter_amp_power_save_en = power_word[`AMGC_BIT_FILTER_AMP_SAVE]; // [R9]

    assign alternative_gain_select = reg_value[IDX_ALTCFG][`AMGC_BIT_ALT_GAIN_SELECT];

    // ****************************************
    // gain code selection
    // ****************************************
    logic [5:0] code_sel [4];

    // alternative codes override the mic gain registers completely [R14]
    assign code_sel[0] = alternative_gain_select ? reg_value[IDX_ALTR][`AMGC_GAIN_MSB:0]
                                                 : reg_value[IDX_RMIC][`AMGC_GAIN_MSB:0];
    assign code_sel[1] = alternative_gain_select ? reg_value[IDX_ALTL][`AMGC_GAIN_MSB:0]
                                                 : reg_value[IDX_LMIC][`AMGC_GAIN_MSB:0];
    // the mic test bit 7 is stored and read back but steers nothing
    assign code_sel[2] = reg_value[IDX_RMON][`AMGC_GAIN_MSB:0];
    assign code_sel[3] = reg_value[IDX_LMON][`AMGC_GAIN_MSB:0];

    // ****************************************
    // gain decoders: two mic, two monitor
    // ****************************************
    amgc_gain_t gain_dec [4];

    generate
        for (gi = 0; gi < 4; gi++) begin : g_dec
            amgc_gain_decode #(
                .MONITOR(gi >= 2)
            ) u_dec (
                .code_in(code_sel[gi]),
                .gain_out(gain_dec[gi])
            ); // [R10] [R11] [R12] [R13]
        end
    endgenerate

    // ****************************************
    // registered control outputs
    // ****************************************
    localparam amgc_gain_t GAIN_MUTED = '{mute: 1'b1, half_db: 6'h00};

    // matches the register defaults: all gains decode to mute
    localparam amgc_ctrl_t CTRL_RESET = '{
        playback_only_disable: 1'b0,
        playback_preamp_power_save: 1'b0,
        playback_filter_amp_right_en: 1'b0,
        playback_filter_amp_left_en: 1'b0,
        slide_switch_power_ctrl: 1'b0,
        headphone_power_save_en: 1'b0,
        mic_amp_power_save_en: 1'b0,
        filter_amp_power_save_en: 1'b0,
        alternative_gain_select: 1'b0,
        right_mic_gain: GAIN_MUTED,
        left_mic_gain: GAIN_MUTED,
        right_monitor_gain: GAIN_MUTED,
        left_monitor_gain: GAIN_MUTED
    };

    amgc_ctrl_t ctrl_r;
    amgc_ctrl_t ctrl_nxt;

    assign ctrl_nxt.playback_only_disable = playback_only_disable;
    assign ctrl_nxt.playback_preamp_power_save = playback_preamp_power_save;
    assign ctrl_nxt.playback_filter_amp_right_en = playback_filter_amp_right_en;
    assign ctrl_nxt.playback_filter_amp_left_en = playback_filter_amp_left_en;
    assign ctrl_nxt.slide_switch_power_ctrl = slide_switch_power_ctrl;
    assign ctrl_nxt.headphone_power_save_en = headphone_power_save_en;
    assign ctrl_nxt.mic_amp_power_save_en = mic_amp_power_save_en;
    assign ctrl_nxt.filter_amp_power_save_en = filter_amp_power_save_en;
    assign ctrl_nxt.alternative_gain_select = alternative_gain_select;
    assign ctrl_nxt.right_mic_gain = gain_dec[0];
    assign ctrl_nxt.left_mic_gain = gain_dec[1];
    assign ctrl_nxt.right_monitor_gain = gain_dec[2];
    assign ctrl_nxt.left_monitor_gain = gain_dec[3];

    // extra flop stage keeps decoder glitches off the analog controls
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_r <= CTRL_RESET; // [R16]
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign ctrl_out = ctrl_r;

endmodule
`default_nettype wire

// >>> test/amgc_bank_asserts.sv
// port assertions for the audio mode and gain bank
`default_nettype none
module amgc_bank_asserts
    import amgc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire amgc_bus_req_t bus_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire amgc_ctrl_t ctrl_out
);
    // ****************************************
    // write data two cycles back, matches ctrl lag
    // ****************************************
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wd1_r <= 8'h00;
            wd2_r <= 8'h00;
        end else begin
            wd1_r <= bus_in.wdata;
            wd2_r <= wd1_r;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_wr(logic [7:0] a);
        bus_in.wr && bus_in.addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        bus_in.rd && bus_in.addr == a;
    endsequence
    a_read_pulse: assert property (bus_in.rd |=> rvalid_out)
        else $error("read gave no valid pulse");
    a_idle_quiet: assert property (!bus_in.rd |=> !rvalid_out && rdata_out == 8'h00)
        else $error("read data outside read cycle");
    a_test_bit_one: assert property (s_rd(8'h16) |=> rdata_out[7])
        else $error("playback test bit read zero");
    a_unlisted_zero: assert property (s_rd(8'h16) |=> rdata_out[5] == 1'b0 && rdata_out[3:2] == 2'b00)
        else $error("unlisted playback bits not zero");
    a_playback_flags: assert property (s_wr(8'h16) |-> ##2
        {ctrl_out.playback_only_disable, ctrl_out.playback_preamp_power_save, ctrl_out.playback_filter_amp_right_en,
        ctrl_out.playback_filter_amp_left_en} == {wd2_r[6], wd2_r[4], wd2_r[1], wd2_r[0]})
        else $error("playback flags not taken from write");
    a_power_flags: assert property (s_wr(8'h17) |-> ##2
        {ctrl_out.slide_switch_power_ctrl, ctrl_out.headphone_power_save_en, ctrl_out.mic_amp_power_save_en,
        ctrl_out.filter_amp_power_save_en} == {wd2_r[7], wd2_r[3], wd2_r[2], wd2_r[0]})
        else $error("power save flags not taken from write");
    // select seen one cycle later is the one in force when the new code reaches ctrl
    a_right_mic_mute: assert property (s_wr(8'h30) ##0 bus_in.wdata[5:0] == 6'h00
        ##1 !ctrl_out.alternative_gain_select |=> ctrl_out.right_mic_gain == 7'h40)
        else $error("right mic code zero not mute");
    a_left_mic_gain: assert property (s_wr(8'h31) ##0 bus_in.wdata[5:0] != 6'h00
        ##1 !ctrl_out.alternative_gain_select |=> ctrl_out.left_mic_gain == {1'b0, wd2_r[5:0] - 6'h01})
        else $error("left mic gain step wrong");
    a_right_mon_gain: assert property (s_wr(8'h32) ##0 (bus_in.wdata[5:0] != 6'h00
        && bus_in.wdata[5:0] < 6'h3e) |-> ##2 ctrl_out.right_monitor_gain == {1'b0, wd2_r[5:0]})
        else $error("right monitor gain step wrong");
    a_left_mon_mute: assert property (s_wr(8'h33) ##0 bus_in.wdata[5:0] == 6'h00
        |-> ##2 ctrl_out.left_monitor_gain.mute)
        else $error("left monitor code zero not mute");
    a_alt_gain_swap: assert property (s_wr(8'h30) ##1 ctrl_out.alternative_gain_select
        |=> $stable(ctrl_out.right_mic_gain))
        else $error("mic register used while alternative selected");
endmodule

bind amgc_bank amgc_bank_asserts u_asserts (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .rvalid_out(rvalid_out),
    .ctrl_out(ctrl_out)
);
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench with a register model for the audio mode and gain bank
`default_nettype none
module testbench
    import amgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    amgc_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic rvalid;
    amgc_ctrl_t ctrl;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] mdl [0:255];
    logic rd_pend = 1'b0;
    logic [7:0] rd_exp;
    logic [7:0] a;
    amgc_ctrl_t q1;
    amgc_ctrl_t q2;
    localparam logic [7:0] MAPPED [9] = '{8'h16, 8'h17, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41, 8'h42};

    amgc_bank uut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus_in(bus), .rdata_out(rdata),
        .rvalid_out(rvalid), .ctrl_out(ctrl));

    always #25 mclk_in = ~mclk_in;

    // ****************************************
    // reference model
    // ****************************************
    function automatic logic [7:0] wmask(input logic [7:0] ad);
        case (ad)
            8'h16: return 8'h53;
            8'h17: return 8'h8d;
            8'h30, 8'h31: return 8'hbf;
            8'h32, 8'h33, 8'h41, 8'h42: return 8'h3f;
            8'h40: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction
    function automatic amgc_gain_t dec(input logic [5:0] c, input logic mon);
        if (c == 6'h00) return '{1'b1, 6'h00};
        if (!mon || c >= 6'h3e) return '{1'b0, c - 6'h01};
        return '{1'b0, c};
    endfunction
    function automatic amgc_ctrl_t ctrl_fn();
        amgc_ctrl_t c;
        logic alt;
        alt = mdl[8'h40][7];
        c.playback_only_disable = mdl[8'h16][6];
        c.playback_preamp_power_save = mdl[8'h16][4];
        c.playback_filter_amp_right_en = mdl[8'h16][1];
        c.playback_filter_amp_left_en = mdl[8'h16][0];
        c.slide_switch_power_ctrl = mdl[8'h17][7];
        c.headphone_power_save_en = mdl[8'h17][3];
        c.mic_amp_power_save_en = mdl[8'h17][2];
        c.filter_amp_power_save_en = mdl[8'h17][0];
        c.alternative_gain_select = alt;
        c.right_mic_gain = dec(alt ? mdl[8'h41][5:0] : mdl[8'h30][5:0], 1'b0);
        c.left_mic_gain = dec(alt ? mdl[8'h42][5:0] : mdl[8'h31][5:0], 1'b0);
        c.right_monitor_gain = dec(mdl[8'h32][5:0], 1'b1);
        c.left_monitor_gain = dec(mdl[8'h33][5:0], 1'b1);
        return c;
    endfunction
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // model runs beside the design; ctrl lags the write by two edges
    always @(posedge mclk_in) begin
        if (!reset_n_in) begin
            foreach (mdl[i]) mdl[i] = 8'h00;
            mdl[8'h16] = 8'h80;
            mdl[8'h30] = 8'h80;
            mdl[8'h31] = 8'h80;
            rd_pend = 1'b0;
            q1 = ctrl_fn();
            q2 = q1;
        end else begin
            chk("ctrl", 64'(ctrl), 64'(q2));
            if (rd_pend) begin
                chk("rdata", 64'(rdata), 64'(rd_exp));
                chk("rvalid", 64'(rvalid), 64'h1);
            end else begin
                chk("rdata idle", 64'(rdata), 64'h0);
                chk("rvalid idle", 64'(rvalid), 64'h0);
            end
            rd_pend = bus.rd;
            rd_exp = mdl[bus.addr];
            if (bus.wr) mdl[bus.addr] = (mdl[bus.addr] & ~wmask(bus.addr)) | (bus.wdata & wmask(bus.addr));
            q2 = q1;
            q1 = ctrl_fn();
        end
    end

    // ****************************************
    // bus tasks, called just after a rising edge
    // ****************************************
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        bus <= '{ad, d, 1'b1, 1'b0};
        @(posedge mclk_in);
    endtask
    task automatic rd(input logic [7:0] ad);
        bus <= '{ad, 8'($urandom), 1'b0, 1'b1};
        @(posedge mclk_in);
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            bus <= '{bus.addr, bus.wdata, 1'b0, 1'b0};
            @(posedge mclk_in);
        end
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(32'hb9ee_ff54));
        repeat (3) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 9; i++) rd(MAPPED[i]);
        rd(8'h00);
        rd(8'h18);
        rd(8'hff);
        idle(1);
        $display("test defaults done");
        // back to back write and read, ones then zeros; software never writes the test bit
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 9; i++) begin
                wr(MAPPED[i], (p == 0 ? 8'hff : 8'h00) & (i == 0 ? 8'h7f : 8'hff));
                rd(MAPPED[i]);
            end
            wr(8'h18, 8'hff);
            rd(8'h18);
        end
        $display("test masks done");
        // each playback and power-save bit set alone in turn; the slide switch bit 7 comes last
        for (int b = 0; b < 8; b++) begin
            wr(8'h16, 8'(1 << b) & 8'h7f);
            wr(8'h17, 8'(1 << b));
            rd(8'h16);
        end
        $display("test flags done");
        for (int c = 0; c < 64; c++) begin
            for (int g = 0; g < 4; g++) wr(8'h30 + 8'(g), {2'($urandom), 6'(c)});
        end
        idle(2);
        $display("test gains done");
        wr(8'h41, 8'h15);
        wr(8'h42, 8'h3f);
        wr(8'h30, 8'h22);
        wr(8'h40, 8'h80);
        idle(2);
        wr(8'h30, 8'h05);
        wr(8'h31, 8'h00);
        idle(2);
        rd(8'h40);
        wr(8'h40, 8'h00);
        idle(3);
        $display("test alternative done");
        // alternative select kept clear so mic checks stay simple
        repeat (400) begin
            a = MAPPED[$urandom_range(8)];
            if (a == 8'h40) a = 8'($urandom) | 8'h80;
            case ($urandom_range(2))
                0: wr(a, 8'($urandom) & (a == 8'h16 ? 8'h7f : 8'hff));
                1: rd(a);
                default: idle(1);
            endcase
        end
        $display("test random done");
        // let the write land so reset has something to undo
        wr(8'h17, 8'h8d);
        idle(1);
        reset_n_in <= 1'b0;
        idle(2);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 9; i++) rd(MAPPED[i]);
        idle(3);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
